// *** src/sbio_port.v ***
// Summary of operation
// - direction 0 drives the latch value, whether or not analog is selected
// - direction 1 makes an input; digital read path off while analog selected
// - after reset pins 1..6 are analog, pin 1 channel 6 up to pin 6 channel 11
// - enabled comparator outputs override the latch on pins 1 and 2
// - reference output on pin 5 kills both its digital drive and input
// - pin 7 is digital only and feeds the serial slave select as input
// - bit 0 of port registers and top two config bits read as zero
// - reading the latch register returns the latch, not the pins
// - after reset pins 6..1 are analog and read back zero
`include "sbio_regs.vh"

module sbio_port #(
    parameter PORT_W = 8
) (
    input wire mclk,
    input wire rst,
    input wire [`SBIO_ADDR_W-1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output wire [7:0] regRdData,
    input wire [PORT_W-1:0] pinIn,
    output wire [PORT_W-1:0] pinOut,
    output wire [PORT_W-1:0] pinOe,
    input wire comparatorOneResult,
    input wire comparatorTwoResult,
    output wire [PORT_W-1:0] analogSelect,
    output wire [2:0] comparatorMode,
    output wire [1:0] converterRefConfig,
    output wire [7:0] voltageReferenceControl,
    output wire serialSlaveSelect
);

    // ======================================================================
    // register storage
    // ======================================================================
    reg [PORT_W-1:0] outLatch_q;
    reg [PORT_W-1:0] direction_q;
    reg [7:0] convCfg_q;
    reg [7:0] cmpCtrl_q;
    reg [7:0] vrefCtrl_q;
    reg [7:0] rdData_q;
    reg [7:0] rdData_d;

    // ======================================================================
    // pin-facing state
    // ======================================================================
    reg [PORT_W-1:0] pinOut_q;
    reg [PORT_W-1:0] pinOe_q;
    reg [PORT_W-1:0] analogSel_q;
    reg slaveSel_q;
    wire [PORT_W-1:0] pinSync;
    wire [PORT_W-1:0] pinOut_d;
    wire [PORT_W-1:0] pinOe_d;
    wire [PORT_W-1:0] analogSel_d;
    wire [PORT_W-1:0] inputEnable;
    wire [PORT_W-1:0] pinLevels;

    // ======================================================================
    // decoded control fields
    // ======================================================================
    wire [3:0] selField;
    wire [2:0] cmpMode;
    wire comparatorsOn;
    wire cmpOutputsOn;
    wire refOutEnable;
    // one enable per register word; the pin level word aliases the latch
    reg wrLatch;
    reg wrDirection;
    reg wrConvCfg;
    reg wrCmpCtrl;
    reg wrVrefCtrl;

    assign selField = convCfg_q[`SBIO_SEL_MSB:`SBIO_SEL_LSB];
    assign cmpMode = cmpCtrl_q[`SBIO_CM_MSB:`SBIO_CM_LSB];
    // any mode but the off code keeps the comparator inputs claimed
    assign comparatorsOn = (cmpMode != `SBIO_CM_OFF);
    assign cmpOutputsOn = (cmpMode == `SBIO_CM_OUTPUTS);
    assign refOutEnable = vrefCtrl_q[`SBIO_REF_OE_BIT];

    // ======================================================================
    // synchronise the pad levels
    // ======================================================================
    sbio_sync #(
        .WIDTH(PORT_W)
    ) uPinSync (
        .mclk(mclk),
        .rst(rst),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    // ======================================================================
    // per-pin steering
    // ======================================================================
    assign pinOut_d[0] = 1'b0;
    assign pinOe_d[0] = 1'b0;
    assign analogSel_d[0] = 1'b0;
    assign inputEnable[0] = 1'b0;
    assign pinLevels[0] = 1'b0;

    genvar p;
    generate
        for (p = 1; p < PORT_W; p = p + 1)
        begin : gPin
            // integer sum first, then its low five bits, so nothing truncates silently
            localparam integer CHAN_NUM = p + `SBIO_CH_OFFSET;
            localparam [4:0] CHANNEL = CHAN_NUM[4:0];
            wire [4:0] chSum;
            wire isAnalog;
            wire cmpInBlock;
            wire refBlock;
            wire periphEn;
            wire periphVal;

            // a larger select code retires the higher channels first; 0Fh clears all
            assign chSum = {1'b0, selField} + CHANNEL;
            assign isAnalog = (p <= `SBIO_LAST_ANALOG_PIN) &&
                (chSum <= `SBIO_LAST_ANALOG_CH);
            assign analogSel_d[p] = isAnalog;

            assign cmpInBlock = comparatorsOn && (p >= `SBIO_CMP_PIN_LO) &&
                (p <= `SBIO_CMP_PIN_HI);
            assign refBlock = (p == `SBIO_VREF_PIN) && refOutEnable;

            assign periphEn = cmpOutputsOn &&
                ((p == `SBIO_CMP_TWO_PIN) || (p == `SBIO_CMP_ONE_PIN));
            assign periphVal = (p == `SBIO_CMP_TWO_PIN) ? comparatorTwoResult :
                comparatorOneResult;

            // analog selection never touches the drive path
            assign pinOe_d[p] = ~direction_q[p] & ~refBlock;
            assign pinOut_d[p] = periphEn ? periphVal : outLatch_q[p];

            assign inputEnable[p] = ~isAnalog & ~cmpInBlock & ~refBlock;
            assign pinLevels[p] = inputEnable[p] & pinSync[p];
        end
    endgenerate

    // ======================================================================
    // pin outputs, registered so the pads see no decode glitches
    // ======================================================================
    always @(posedge mclk)
    begin
        if (rst)
        begin
            pinOut_q <= {PORT_W{1'b0}};
            pinOe_q <= {PORT_W{1'b0}};
            analogSel_q <= {PORT_W{1'b0}};
        end
        else
        begin
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
            analogSel_q <= analogSel_d;
        end
    end

    // ======================================================================
    // serial slave select from pin 7
    // ======================================================================
    always @(posedge mclk)
    begin
        if (rst)
        begin
            slaveSel_q <= 1'b1;
        end
        else if (direction_q[`SBIO_SSEL_PIN])
        begin
            slaveSel_q <= pinSync[`SBIO_SSEL_PIN];
        end
        else
        begin
            // select idles inactive high while the pin is an output
            slaveSel_q <= 1'b1;
        end
    end

    // ======================================================================
    // register write decode
    // ======================================================================
    always @*
    begin
        wrLatch = 1'b0;
        wrDirection = 1'b0;
        wrConvCfg = 1'b0;
        wrCmpCtrl = 1'b0;
        wrVrefCtrl = 1'b0;
        if (regWrStb)
        begin
            if (regAddr == `SBIO_ADDR_PIN_LEVELS)
            begin
                wrLatch = 1'b1;
            end
            else if (regAddr == `SBIO_ADDR_OUT_LATCH)
            begin
                wrLatch = 1'b1;
            end
            else if (regAddr == `SBIO_ADDR_DIRECTION)
            begin
                wrDirection = 1'b1;
            end
            else if (regAddr == `SBIO_ADDR_CONV_CFG)
            begin
                wrConvCfg = 1'b1;
            end
            else if (regAddr == `SBIO_ADDR_CMP_CTRL)
            begin
                wrCmpCtrl = 1'b1;
            end
            else if (regAddr == `SBIO_ADDR_VREF_CTRL)
            begin
                // unmapped words fall through and are dropped
                wrVrefCtrl = 1'b1;
            end
        end
    end

    // ======================================================================
    // register writes
    // ======================================================================
    always @(posedge mclk)
    begin
        if (rst)
        begin
            outLatch_q <= `SBIO_RST_OUT_LATCH;
            direction_q <= `SBIO_RST_DIRECTION;
            convCfg_q <= `SBIO_RST_CONV_CFG;
            cmpCtrl_q <= `SBIO_RST_CMP_CTRL;
            vrefCtrl_q <= `SBIO_RST_VREF_CTRL;
        end
        else
        begin
            if (wrLatch)
            begin
                outLatch_q <= regWrData & `SBIO_PORT_MASK;
            end
            if (wrDirection)
            begin
                direction_q <= regWrData & `SBIO_PORT_MASK;
            end
            if (wrConvCfg)
            begin
                // 0Fh here turns every shared pin digital
                convCfg_q <= regWrData & `SBIO_CONV_CFG_MASK;
            end
            if (wrCmpCtrl)
            begin
                // result bits are live comparator state, not storage
                cmpCtrl_q <= regWrData & `SBIO_CMP_CTRL_WMASK;
            end
            if (wrVrefCtrl)
            begin
                vrefCtrl_q <= regWrData;
            end
        end
    end

    // ======================================================================
    // read views, unimplemented bits forced low
    // ======================================================================
    wire [7:0] latchView;
    wire [7:0] directionView;
    wire [7:0] convCfgView;
    wire [7:0] cmpCtrlView;

    // pin levels need no view: the per-pin steering already masks them
    assign latchView = outLatch_q & `SBIO_PORT_MASK;
    assign directionView = direction_q & `SBIO_PORT_MASK;
    assign convCfgView = convCfg_q & `SBIO_CONV_CFG_MASK;
    // result bits are sampled live from the comparators, never stored
    assign cmpCtrlView = {comparatorTwoResult, comparatorOneResult, cmpCtrl_q[5:0]};

    // ======================================================================
    // register reads, data one cycle after the strobe
    // ======================================================================
    always @*
    begin
        rdData_d = 8'h00;
        if (regRdStb)
        begin
            if (regAddr == `SBIO_ADDR_PIN_LEVELS)
            begin
                rdData_d = pinLevels;
            end
            else if (regAddr == `SBIO_ADDR_OUT_LATCH)
            begin
                rdData_d = latchView;
            end
            else if (regAddr == `SBIO_ADDR_DIRECTION)
            begin
                rdData_d = directionView;
            end
            else if (regAddr == `SBIO_ADDR_CONV_CFG)
            begin
                rdData_d = convCfgView;
            end
            else if (regAddr == `SBIO_ADDR_CMP_CTRL)
            begin
                rdData_d = cmpCtrlView;
            end
            else if (regAddr == `SBIO_ADDR_VREF_CTRL)
            begin
                rdData_d = vrefCtrl_q;
            end
            else
            begin
                rdData_d = 8'h00;
            end
        end
    end

    // ======================================================================
    // read data register, zero outside the answer cycle
    // ======================================================================
    always @(posedge mclk)
    begin
        if (rst)
        begin
            rdData_q <= 8'h00;
        end
        else
        begin
            rdData_q <= rdData_d;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign regRdData = rdData_q;
    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign analogSelect = analogSel_q;
    assign comparatorMode = cmpMode;
    assign converterRefConfig = convCfg_q[`SBIO_VCFG_MSB:`SBIO_VCFG_LSB];
    assign voltageReferenceControl = vrefCtrl_q;
    assign serialSlaveSelect = slaveSel_q;

endmodule

// *** src/sbio_regs.vh ***
`ifndef SBIO_REGS_VH
`define SBIO_REGS_VH

// ==========================================================================
// register word indices on the plain register port
// ==========================================================================
`define SBIO_ADDR_W 3
`define SBIO_ADDR_PIN_LEVELS 3'h0
`define SBIO_ADDR_OUT_LATCH 3'h1
`define SBIO_ADDR_DIRECTION 3'h2
`define SBIO_ADDR_CONV_CFG 3'h3
`define SBIO_ADDR_CMP_CTRL 3'h4
`define SBIO_ADDR_VREF_CTRL 3'h5

// ==========================================================================
// reset values
// ==========================================================================
`define SBIO_RST_OUT_LATCH 8'h00
`define SBIO_RST_DIRECTION 8'hFE
`define SBIO_RST_CONV_CFG 8'h00
`define SBIO_RST_CMP_CTRL 8'h07
`define SBIO_RST_VREF_CTRL 8'h00

// ==========================================================================
// field positions and masks
// ==========================================================================
`define SBIO_PORT_MASK 8'hFE
`define SBIO_CONV_CFG_MASK 8'h3F
`define SBIO_SEL_LSB 0
`define SBIO_SEL_MSB 3
`define SBIO_VCFG_LSB 4
`define SBIO_VCFG_MSB 5
`define SBIO_CM_LSB 0
`define SBIO_CM_MSB 2
`define SBIO_CMP_CTRL_WMASK 8'h3F
`define SBIO_CMP_ONE_BIT 6
`define SBIO_CMP_TWO_BIT 7
`define SBIO_REF_OE_BIT 6

// ==========================================================================
// mode encodings and pin map
// ==========================================================================
`define SBIO_CM_OFF 3'h7
`define SBIO_CM_OUTPUTS 3'h3
`define SBIO_LAST_ANALOG_CH 5'h0E
`define SBIO_CH_OFFSET 5
`define SBIO_CMP_PIN_LO 3
`define SBIO_CMP_PIN_HI 6
`define SBIO_LAST_ANALOG_PIN 6
`define SBIO_CMP_TWO_PIN 1
`define SBIO_CMP_ONE_PIN 2
`define SBIO_VREF_PIN 5
`define SBIO_SSEL_PIN 7
`define SBIO_SYNC_STAGES 2

`endif

// *** src/sbio_sync.v ***
// ==========================================================================
// per-bit two-flop synchroniser for asynchronous pin levels
// ==========================================================================
module sbio_sync #(
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rst,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1)
        begin : gBit
            reg meta_q;
            reg stable_q;
            // the first stage is read by the second stage only
            always @(posedge mclk)
            begin
                if (rst)
                begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end
                else
                begin
                    meta_q <= asyncIn[b];
                    stable_q <= meta_q;
                end
            end
            assign syncOut[b] = stable_q;
        end
    endgenerate

endmodule

// *** test/sbio_port_asserts.sv ***
`include "sbio_regs.vh"
// ==========================================
// port checker
// ==========================================
module sbio_port_asserts #(
    parameter PORT_W = 8
) (
    input wire mclk,
    input wire rst,
    input wire [`SBIO_ADDR_W-1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    input wire [7:0] regRdData,
    input wire [PORT_W-1:0] pinOut,
    input wire [PORT_W-1:0] pinOe,
    input wire comparatorOneResult,
    input wire comparatorTwoResult,
    input wire [PORT_W-1:0] analogSelect,
    input wire [2:0] comparatorMode,
    input wire [7:0] voltageReferenceControl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_bit0_idle: assert property (pinOe[0] == 1'b0 && pinOut[0] == 1'b0)
        else $error("bit 0 pad active");
    chk_reset_analog: assert property ($fell(rst) && !regWrStb |=> analogSelect == 8'h7E)
        else $error("analog default wrong");
    chk_pin7_digital: assert property (analogSelect[7] == 1'b0)
        else $error("pin 7 analog");
    chk_vref_drive: assert property (voltageReferenceControl[6] |=> pinOe[5] == 1'b0)
        else $error("pin 5 driven under vref");
    chk_cmp_two: assert property (comparatorMode == 3'h3 |=>
        pinOe[1] == 1'b0 || pinOut[1] == $past(comparatorTwoResult))
        else $error("pin 1 not comparator");
    chk_cmp_one: assert property (comparatorMode == 3'h3 ##1 pinOe[2] |->
        pinOut[2] == $past(comparatorOneResult))
        else $error("pin 2 not comparator");
    chk_rd_bit0: assert property (regRdStb && regAddr <= 3'h2 |=> regRdData[0] == 1'b0)
        else $error("bit 0 reads one");
    chk_cfg_top: assert property (regRdStb && regAddr == 3'h3 |=> regRdData[7:6] == 2'b00)
        else $error("config top bits set");
    chk_latch_back: assert property (regWrStb && regAddr <= 3'h1 ##1 !regWrStb
        ##1 regRdStb && regAddr == 3'h1 |=> regRdData == ($past(regWrData, 3) & 8'hFE))
        else $error("latch readback wrong");
    chk_analog_mask: assert property (regRdStb && regAddr == 3'h0
        ##1 $stable(analogSelect) |-> (regRdData & analogSelect) == 8'h00)
        else $error("analog pin reads one");
endmodule

bind sbio_port sbio_port_asserts #(.PORT_W(PORT_W)) chk (.mclk(mclk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .pinOut(pinOut), .pinOe(pinOe),
    .comparatorOneResult(comparatorOneResult), .comparatorTwoResult(comparatorTwoResult),
    .analogSelect(analogSelect), .comparatorMode(comparatorMode),
    .voltageReferenceControl(voltageReferenceControl));

// *** test/sbio_board.sv ***
// ==========================================
// board side of the pads
// ==========================================
module sbio_board (
    input wire [7:0] pinOut,
    input wire [7:0] pinOe,
    input wire [7:0] extVal,
    output wire [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // a pad the port drives reads back that drive, else the board level
    assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
endmodule

// *** test/sbio_port_tb.sv ***
// ==========================================
// port bench
// ==========================================
module sbio_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic cmpOne = 1'b0;
    logic cmpTwo = 1'b0;
    logic [7:0] extVal = 8'hAA;
    logic [7:0] rdv;
    wire [7:0] regRdData;
    wire [7:0] pinIn;
    wire [7:0] pinOut;
    wire [7:0] pinOe;
    wire [7:0] analogSelect;
    wire ssel;
    wire [2:0] cmpMode;
    wire [1:0] refCfg;
    wire [7:0] vrefCtl;
    int failCount = 0;
    int numChecks = 0;

    always #2.5 mclk = ~mclk;

    sbio_port DUT (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .comparatorOneResult(cmpOne),
        .comparatorTwoResult(cmpTwo), .analogSelect(analogSelect), .comparatorMode(cmpMode),
        .converterRefConfig(refCfg), .voltageReferenceControl(vrefCtl),
        .serialSlaveSelect(ssel));
    sbio_board BOARD (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .pinIn(pinIn));

    // ==========================================
    // bus and compare helpers
    // ==========================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            failCount++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // a gap cycle follows each strobe so no edge sees it set twice
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1 rdv = regRdData;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // scenarios
    // ==========================================
    task automatic tResetState();
        logic [7:0] ev [6] = '{8'h80, 8'h00, 8'hFE, 8'h00, 8'h07, 8'h00};
        // the pad synchroniser needs two edges after reset before pin 7 shows
        settle(2);
        for (int i = 0; i < 6; i++)
        begin
            rd(i[2:0]);
            chk(rdv, ev[i]);
        end
        chk(analogSelect, 8'h7E);
    endtask
    task automatic tDigital();
        wr(3'h4, 8'h07);
        wr(3'h3, 8'h0F);
        wr(3'h2, 8'hCE);
        wr(3'h0, 8'h34);
        rd(3'h1);
        chk(rdv, 8'h34);
        settle(4);
        chk(pinOe, 8'h30);
        chk(pinOut & pinOe, 8'h30);
        rd(3'h0);
        chk(rdv, 8'hBA);
    endtask
    task automatic tAnalogVref();
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h00);
        wr(3'h1, 8'hFE);
        settle(4);
        chk(pinOe, 8'hFE);
        chk(pinOut, 8'hFE);
        rd(3'h0);
        chk(rdv, 8'h80);
        wr(3'h5, 8'h40);
        wr(3'h3, 8'h0F);
        settle(4);
        chk(vrefCtl, 8'h40);
        chk(pinOe, 8'hDE);
        rd(3'h0);
        chk(rdv, 8'hDE);
        wr(3'h5, 8'h00);
    endtask
    task automatic tComparator();
        wr(3'h4, 8'h03);
        cmpTwo <= 1'b1;
        settle(3);
        chk({5'h00, cmpMode}, 8'h03);
        chk(pinOut & 8'h06, 8'h02);
        @(posedge mclk);
        cmpTwo <= 1'b0;
        cmpOne <= 1'b1;
        settle(3);
        chk(pinOut & 8'h06, 8'h04);
        rd(3'h0);
        chk(rdv, 8'h84);
        rd(3'h4);
        chk(rdv, 8'h43);
        wr(3'h4, 8'h07);
    endtask
    task automatic tSlaveSelect();
        wr(3'h2, 8'h80);
        extVal <= 8'h2A;
        settle(5);
        chk({7'h00, ssel}, 8'h00);
        @(posedge mclk);
        extVal <= 8'hAA;
        settle(5);
        chk({7'h00, ssel}, 8'h01);
    endtask
    task automatic tBits();
        logic [7:0] ev [3] = '{8'hFE, 8'hFE, 8'h3F};
        for (int i = 0; i < 3; i++)
        begin
            wr(3'(i + 1), 8'hFF);
            rd(3'(i + 1));
            chk(rdv, ev[i]);
        end
        chk({6'h00, refCfg}, 8'h03);
        rd(3'h6);
        chk(rdv, 8'h00);
    endtask

    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        tResetState();
        tDigital();
        tAnalogVref();
        tComparator();
        tSlaveSelect();
        tBits();
        conclude();
    end
    initial
    begin
        #100000;
        failCount++;
        conclude();
    end
endmodule
